// File: pwmc_bus.sv
/*
  avalon-mm wait-state sequencer: each request sees waitrequest high for
  two cycles, then low for one; access pulses in the cycle before that.
  assumes the master holds its request until waitrequest is sampled low.
*/
`timescale 1ns/10ps
module pwmc_bus import pwmc_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic req,
  output logic waitrequest,
  output logic access
);

  typedef struct packed {
    pwmc_bus_ph_t ph;
    logic waitreq;
  } pwmc_bus_st_t;

  pwmc_bus_st_t st;
  pwmc_bus_st_t next_st;

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  // the extra cycle lets the buffer memory present registered read data
  always_comb begin
    next_st = st;
    unique case (st.ph)
      PWMC_IDLE: if (req) next_st.ph = PWMC_GRAB;
      PWMC_GRAB: begin
        next_st.ph = PWMC_DONE;
        next_st.waitreq = 1'b0;
      end
      PWMC_DONE: begin
        next_st.ph = PWMC_IDLE;
        next_st.waitreq = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '{ph: PWMC_IDLE, waitreq: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  // kept in its bus polarity so the slave output has no gate after its flop
  assign waitrequest = st.waitreq;
  assign access = (st.ph == PWMC_GRAB);

  chk_bus_answer: assert property (@(posedge clk) disable iff (!nrst)
    req && st.ph == PWMC_IDLE |=> ##1 !waitrequest ##1 waitrequest)
    else $error("bus answer not two cycles after request");

endmodule : pwmc_bus

// File: pwmc_mem.sv
/*
  sixteen-byte buffer store for period (0..7) and duty (8..15) values,
  registered read port plus all words in parallel for the channels.
  assumes one write per cycle at most.
*/
`timescale 1ns/10ps
`include "pwmc_regs.svh"
module pwmc_mem import pwmc_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic we,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic [15:0][7:0] words
);

  typedef struct packed {
    logic [15:0][7:0] word;
    logic [7:0] rdata;
  } pwmc_mem_st_t;

  pwmc_mem_st_t st;
  pwmc_mem_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.rdata = st.word[addr];
    if (we) next_st.word[addr] = wdata;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '{word: {16{`PWMC_RST_BUF}}, rdata: 8'h00};
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign words = st.word;

endmodule : pwmc_mem

// File: pwmc_pkg.sv
/*
  types shared by the pwm channel block: bus request, tick inputs,
  channel state and per-channel configuration carrier.
  assumes nothing of its surroundings.
*/
package pwmc_pkg;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } pwmc_avs_req_t;

  typedef struct packed {
    logic a;
    logic sa;
    logic b;
    logic sb;
  } pwmc_ticks_t;

  typedef struct packed {
    logic en;
    logic tick;
    logic center;
    logic pol;
    logic clr;
    logic [15:0] per;
    logic [15:0] dty;
  } pwmc_core_cfg_t;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] per;
    logic [15:0] dty;
    logic down;
    logic out;
  } pwmc_chan_t;

  typedef enum logic [1:0] {PWMC_IDLE, PWMC_GRAB, PWMC_DONE} pwmc_bus_ph_t;

endpackage : pwmc_pkg

// File: pwmc_regs.svh
/*
  register map, field positions and reset values of the pwm channel block.
  assumes word-aligned avalon byte addresses; index = address[7:2].
*/
`ifndef PWMC_REGS_SVH
`define PWMC_REGS_SVH

// ----------------------------------------------------------------------
// word indices of control registers (group 0)
// ----------------------------------------------------------------------
`define PWMC_IDX_ENABLE 6'h00
`define PWMC_IDX_POL 6'h01
`define PWMC_IDX_CLKSEL 6'h02
`define PWMC_IDX_ALIGN 6'h03
`define PWMC_IDX_JOIN 6'h04
`define PWMC_IDX_PINS 6'h05

// ----------------------------------------------------------------------
// per-channel groups: index[5:3] selects group, index[2:0] the channel
// ----------------------------------------------------------------------
`define PWMC_GRP_CTRL 3'h0
`define PWMC_GRP_CNT 3'h1
`define PWMC_GRP_PER 3'h2
`define PWMC_GRP_DTY 3'h3
`define PWMC_MEM_DTY_OFS 4'h8

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PWMC_RST_CTRL 8'h00
`define PWMC_RST_JOIN 4'h0
`define PWMC_RST_BUF 8'h00

`endif

// File: pwmc_tb.sv
/*
  self-checking testbench of pwmc_top: avalon tasks, pin measurement, scenarios.
  assumes tick inputs driven from this bench; the cycle ceiling ends any stalled wait.
*/
`timescale 1ns/10ps
module tb import pwmc_pkg::*;;
  logic clk;
  logic nrst;
  pwmc_avs_req_t avs_req;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  pwmc_ticks_t ticks;
  logic [7:0] wave_pin;
  logic [1:0] tk;
  int fail_count;
  int samples_checked;
  int cycles;

  pwmc_top pwmc_top_i (
    .clk(clk),
    .nrst(nrst),
    .avs_req(avs_req),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .ticks(ticks),
    .wave_pin(wave_pin)
  );

  // ----------------------------------------------------------------------
  // clock, ticks and timeout
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // a and b tick every cycle, sa every second, sb every fourth cycle
  always @(posedge clk) begin
    tk <= tk + 2'h1;
    ticks.sa <= ~tk[0];
    ticks.sb <= (tk == 2'h3);
    cycles++;
    if (cycles == 30000) begin
      fail("timeout");
      close_out();
    end
  end

  // ----------------------------------------------------------------------
  // reporting and bus tasks
  // ----------------------------------------------------------------------
  task fail(input string m);
    fail_count++;
    $display("unexpected %0t %s", $time, m);
  endtask : fail

  task chk32(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) fail($sformatf("%s got %h want %h", m, got, exp));
  endtask : chk32

  task chkn(input int got, input int exp, input string m);
    samples_checked++;
    if (got != exp) fail($sformatf("%s got %0d want %0d", m, got, exp));
  endtask : chkn

  // request held until waitrequest is sampled low, released on that edge
  task bus(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic be,
           output logic [31:0] rd);
    @(posedge clk);
    avs_req.address <= a;
    avs_req.write <= wr;
    avs_req.read <= ~wr;
    avs_req.writedata <= {24'h0, d};
    avs_req.byteenable <= {3'h0, be};
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_req.write <= 1'b0;
    avs_req.read <= 1'b0;
  endtask : bus

  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, 1'b1, rd);
  endtask : wr

  task rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 8'h00, 1'b1, rd);
    chk32(rd, {24'h0, exp}, $sformatf("read %h", a));
  endtask : rdchk

  // counts high cycles and rising edges of one pin over w cycles
  task meas(input int ch, input int w, output int hi, output int ri);
    logic prev;
    hi = 0;
    ri = 0;
    prev = wave_pin[ch];
    repeat (w) begin
      @(posedge clk);
      if (wave_pin[ch] === 1'b1) hi++;
      if (wave_pin[ch] === 1'b1 && prev !== 1'b1) ri++;
      prev = wave_pin[ch];
    end
  endtask : meas

  // window of eight whole periods makes the counts independent of phase
  task run(input int ch, input logic [7:0] per, input logic [7:0] dty, input logic pol,
           input logic ctr, input logic pick, input int pk, input int hp);
    int hi;
    int ri;
    logic [31:0] rd;
    wr(8'h04, {7'h0, pol} << ch);
    wr(8'h0c, {7'h0, ctr} << ch);
    wr(8'h08, {7'h0, pick} << ch);
    wr(8'h40 + 8'(ch * 4), per);
    wr(8'h60 + 8'(ch * 4), dty);
    wr(8'h20 + 8'(ch * 4), 8'h00);
    wr(8'h00, 8'h01 << ch);
    repeat (2 * pk + 8) @(posedge clk);
    meas(ch, 8 * pk, hi, ri);
    chkn(hi, 8 * hp, "high cycles");
    chkn(ri, (hp > 0 && hp < pk) ? 8 : 0, "rising edges");
    if (hp == 0 || hp == pk) begin
      bus(1'b0, 8'h14, 8'h00, 1'b1, rd);
      chk32(rd & (32'h1 << ch), (hp == pk) ? (32'h1 << ch) : 32'h0, "pin level");
    end
    wr(8'h00, 8'h00);
    repeat (4) @(posedge clk);
    chk32({31'h0, wave_pin[ch]}, 32'h0, "disabled pin");
    $display("test run ch%0d per %0d duty %0d done", ch, per, dty);
  endtask : run

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task t_regs;
    logic [31:0] rd;
    for (int i = 0; i < 6; i++) rdchk(8'(i * 4), 8'h00);
    wr(8'h10, 8'hff);
    rdchk(8'h10, 8'h0f);
    wr(8'h10, 8'h00);
    wr(8'he0, 8'h5a);
    rdchk(8'he0, 8'h00);
    bus(1'b1, 8'h04, 8'hff, 1'b0, rd);
    rdchk(8'h04, 8'h00);
    wr(8'h14, 8'hff);
    rdchk(8'h14, 8'h00);
    wr(8'h40, 8'ha5);
    rdchk(8'h40, 8'ha5);
    $display("test regs done");
  endtask : t_regs

  task t_modes;
    run(0, 8'd4, 8'd1, 1'b0, 1'b0, 1'b0, 4, 3);
    run(4, 8'd5, 8'd2, 1'b1, 1'b0, 1'b0, 5, 2);
    run(2, 8'd4, 8'd1, 1'b0, 1'b1, 1'b0, 8, 6);
    run(6, 8'd4, 8'd1, 1'b1, 1'b1, 1'b0, 8, 2);
    run(3, 8'd4, 8'd1, 1'b0, 1'b0, 1'b1, 16, 12);
  endtask : t_modes

  task t_bounds;
    run(1, 8'd4, 8'd0, 1'b1, 1'b0, 1'b0, 4, 0);
    run(1, 8'd4, 8'd0, 1'b0, 1'b0, 1'b0, 4, 4);
    run(5, 8'd4, 8'd0, 1'b1, 1'b1, 1'b0, 8, 0);
    run(7, 8'd0, 8'd3, 1'b1, 1'b0, 1'b0, 4, 4);
    run(7, 8'd0, 8'd3, 1'b0, 1'b1, 1'b0, 4, 0);
    run(0, 8'd4, 8'd4, 1'b1, 1'b0, 1'b0, 4, 4);
    run(2, 8'd4, 8'd9, 1'b0, 1'b1, 1'b0, 8, 0);
  endtask : t_bounds

  // even half set to opposite polarity, scaled clock and center mode on purpose
  task t_join;
    int hi;
    int ri;
    wr(8'h10, 8'h01);
    wr(8'h04, 8'h01);
    wr(8'h08, 8'h01);
    wr(8'h0c, 8'h01);
    wr(8'h40, 8'h01);
    wr(8'h44, 8'h02);
    wr(8'h60, 8'h00);
    wr(8'h64, 8'h80);
    wr(8'h24, 8'h00);
    wr(8'h00, 8'h01);
    repeat (20) @(posedge clk);
    meas(1, 40, hi, ri);
    chkn(hi, 0, "even enable alone");
    rdchk(8'h24, 8'h00);
    wr(8'h00, 8'h03);
    repeat (524) @(posedge clk);
    meas(1, 2064, hi, ri);
    chkn(hi, 8 * 130, "joined high cycles");
    chkn(ri, 8, "joined rising edges");
    meas(0, 600, hi, ri);
    chkn(hi, 0, "even pin of pair");
    wr(8'h00, 8'h00);
    wr(8'h20, 8'h55);
    rdchk(8'h24, 8'h00);
    rdchk(8'h20, 8'h00);
    wr(8'h10, 8'h00);
    $display("test join done");
  endtask : t_join

  // ----------------------------------------------------------------------
  // main sequence and verdict
  // ----------------------------------------------------------------------
  task close_out;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  initial begin
    nrst = 1'b0;
    avs_req = '0;
    ticks = 4'b1010;
    tk = 2'h0;
    fail_count = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_modes();
    t_bounds();
    t_join();
    close_out();
  end
endmodule : tb

// File: pwmc_top.sv
/*
  eight-channel 8-bit pwm waveform core with pair joining into 16-bit
  channels, left/center alignment and boundary handling, behind an
  avalon-mm slave with waitrequest.
  assumes the prescaled clocks a, sa, b, sb arrive as one-cycle tick
  pulses synchronous to clk; they are produced elsewhere.
*/
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "pwmc_regs.svh"

// Functional notes
// R1: alignment bit clear gives left-aligned output, set gives center-aligned.
// R2: left mode counts up only; duty match toggles the output.
// R3: left mode period match clears counter and output, loads buffered values.
// R4: left mode counts 0 to period minus one; frequency is clock over period.
// R5: software sets alignment before enabling; switching while running is irregular.
// R6: center mode counts up and down; direction forced up at zero.
// R7: center mode period match turns count down without clearing counter.
// R8: center mode toggles output at duty match going up and going down.
// R9: center mode reaching zero going down turns up and loads buffers.
// R10: center mode period is twice the period value.
// R11: four join bits merge pairs 0/1, 2/3, 4/5, 6/7 into 16-bit channels.
// R12: software changes a join bit only with both pair channels disabled.
// R13: in a pair the even channel holds the high byte, odd the low.
// R14: joined channel uses odd channel clock pick, polarity and output pin.
// R15: joined channel enabled by odd bit only; even output held disabled.
// R16: joined mode: writing either counter byte clears the whole 16-bit counter.
// R17: software reads a joined counter with one coherent access; the code returns it one byte per read, high at the even index.
// R18: joined channel alignment comes from odd channel; even bit ignored.
// R19: zero duty with nonzero period: output low if polarity 1, else high.
// R20: zero period holds counter at zero; output equals polarity.
// R21: duty at or above period: output equals polarity, all modes and widths.
// R22: polarity set starts high and drops at duty; clear starts low.
// R23: joined mode compares and checks boundaries on full 16-bit values.
module pwmc_top import pwmc_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire pwmc_avs_req_t avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire pwmc_ticks_t ticks,
  output logic [7:0] wave_pin
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] channel_enable;
    logic [7:0] polarity_reg;
    logic [7:0] channel_clock_pick;
    logic [7:0] alignment_select_reg;
    logic [3:0] pair_join_control_reg;
    logic [31:0] rdata;
    logic [7:0] pins;
    pwmc_chan_t [7:0] ch;
  } pwmc_top_st_t;

  pwmc_top_st_t st;
  pwmc_top_st_t next_st;
  pwmc_core_cfg_t [7:0] cfg;
  logic [7:0] clr;
  logic [7:0] rbyte;
  logic access;
  logic mem_we;
  logic [7:0] mem_rdata;
  logic [15:0][7:0] mem_words;
  logic [5:0] idx;
  logic [2:0] grp;
  logic [2:0] chn;

  assign idx = avs_req.address[7:2];
  assign grp = idx[5:3];
  assign chn = idx[2:0];

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  // channels 0,1,4,5 use a/sa, channels 2,3,6,7 use b/sb
  function automatic logic chan_tick(input logic [2:0] n, input logic pick,
                                     input pwmc_ticks_t t);
    logic r;
    r = n[1] ? (pick ? t.sb : t.b) : (pick ? t.sa : t.a);
    return r;
  endfunction : chan_tick

  // channel whose counter a counter write clears
  function automatic logic [2:0] clr_target(input logic [2:0] n, input logic [3:0] jn);
    logic [2:0] r;
    r = jn[n[2:1]] ? {n[2:1], 1'b1} : n;
    return r;
  endfunction : clr_target

  // waveform level from the active compare values
  function automatic logic wave_level(input pwmc_chan_t c, input pwmc_core_cfg_t f);
    logic r;
    // a level compare, not a toggle, so a skipped match cannot leave the wave inverted
    if (!f.en) r = 1'b0;
    else if (c.per == 16'h0000) r = f.pol; // [R20]
    else if (c.dty == 16'h0000) r = !f.pol; // [R19]
    else if (c.dty >= c.per) r = f.pol; // [R21]
    else if (c.down) r = (c.cnt <= c.dty) ? f.pol : !f.pol; // [R8] [R22]
    else r = (c.cnt < c.dty) ? f.pol : !f.pol; // [R2] [R22]
    return r;
  endfunction : wave_level

  // one clock of a channel counter
  function automatic pwmc_chan_t step_chan(input pwmc_chan_t c, input pwmc_core_cfg_t f);
    pwmc_chan_t n;
    logic load;
    logic dn;
    n = c;
    load = 1'b0;
    dn = (c.cnt == 16'h0000) ? 1'b0 : c.down;
    n.out = wave_level(c, f);
    if (f.clr) begin
      n.cnt = 16'h0000;
      n.down = 1'b0;
      load = 1'b1;
    end else if (!f.en) begin
      // stopped; new buffer values pass straight through
      load = 1'b1;
      if (f.tick && f.per == 16'h0000) n.cnt = 16'h0000;
    end else if (c.per == 16'h0000) begin
      // parked at zero even between ticks, so a late enable never shows an old count
      n.cnt = 16'h0000; // [R20]
    end else if (f.tick) begin
      if (!f.center) begin
        if (c.cnt >= c.per - 16'h0001) begin
          n.cnt = 16'h0000; // [R3]
          load = 1'b1;
        end else begin
          n.cnt = c.cnt + 16'h0001;
        end
      end else begin
        n.down = dn; // [R6]
        if (!dn && c.cnt < c.per) begin
          n.cnt = c.cnt + 16'h0001;
        end else if (c.cnt == 16'h0001) begin
          // bottom reached (also the turn when period is one)
          n.cnt = 16'h0000; // [R9]
          n.down = 1'b0;
          load = 1'b1;
        end else begin
          n.cnt = c.cnt - 16'h0001; // [R7]
          n.down = 1'b1;
        end
      end
    end
    if (load) begin
      n.per = f.per;
      n.dty = f.dty;
    end
    return n;
  endfunction : step_chan

  // ----------------------------------------------------------------------
  // bus sequencing and buffer store
  // ----------------------------------------------------------------------
  pwmc_bus pwmc_bus_i (
    .clk(clk),
    .nrst(nrst),
    .req(avs_req.read || avs_req.write),
    .waitrequest(avs_waitrequest),
    .access(access)
  );

  assign mem_we = access && avs_req.write && avs_req.byteenable[0]
                  && (grp == `PWMC_GRP_PER || grp == `PWMC_GRP_DTY);

  // period and duty are double buffered: software writes land here only
  pwmc_mem pwmc_mem_i (
    .clk(clk),
    .nrst(nrst),
    .we(mem_we),
    .addr(idx[3:0]),
    .wdata(avs_req.writedata[7:0]),
    .rdata(mem_rdata),
    .words(mem_words)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    cfg = '0;
    clr = 8'h00;
    rbyte = 8'h00;

    // register writes
    if (access && avs_req.write && avs_req.byteenable[0]) begin
      if (grp == `PWMC_GRP_CTRL) begin
        case (idx)
          `PWMC_IDX_ENABLE: next_st.channel_enable = avs_req.writedata[7:0];
          `PWMC_IDX_POL: next_st.polarity_reg = avs_req.writedata[7:0];
          `PWMC_IDX_CLKSEL: next_st.channel_clock_pick = avs_req.writedata[7:0];
          `PWMC_IDX_ALIGN: next_st.alignment_select_reg = avs_req.writedata[7:0]; // [R1]
          `PWMC_IDX_JOIN: next_st.pair_join_control_reg = avs_req.writedata[3:0]; // [R11]
          default: ;
        endcase
      end
      if (grp == `PWMC_GRP_CNT) clr[clr_target(chn, st.pair_join_control_reg)] = 1'b1; // [R16]
    end

    // register reads; reserved bits read zero
    if (grp == `PWMC_GRP_CTRL) begin
      case (idx)
        `PWMC_IDX_ENABLE: rbyte = st.channel_enable;
        `PWMC_IDX_POL: rbyte = st.polarity_reg;
        `PWMC_IDX_CLKSEL: rbyte = st.channel_clock_pick;
        `PWMC_IDX_ALIGN: rbyte = st.alignment_select_reg;
        `PWMC_IDX_JOIN: rbyte = {4'h0, st.pair_join_control_reg};
        `PWMC_IDX_PINS: rbyte = st.pins;
        default: rbyte = 8'h00;
      endcase
    end else if (grp == `PWMC_GRP_CNT) begin
      if (st.pair_join_control_reg[chn[2:1]]) begin
        // even index returns high byte of the odd channel's 16-bit count
        rbyte = chn[0] ? st.ch[chn].cnt[7:0] : st.ch[{chn[2:1], 1'b1}].cnt[15:8]; // [R13]
      end else begin
        rbyte = st.ch[chn].cnt[7:0];
      end
    end else if (grp == `PWMC_GRP_PER || grp == `PWMC_GRP_DTY) begin
      rbyte = mem_rdata;
    end
    if (access && avs_req.read) next_st.rdata = {24'h000000, rbyte};

    // channel configuration and counters
    for (int i = 0; i < 8; i++) begin
      logic j;
      logic odd;
      logic [2:0] ci;
      logic [2:0] hi;
      j = st.pair_join_control_reg[i / 2];
      odd = (i % 2) == 1;
      ci = 3'(i);
      hi = 3'(i & 6);
      // even half of a joined pair stays off whatever its enable says
      cfg[i].en = j ? (odd && st.channel_enable[i]) : st.channel_enable[i]; // [R15]
      cfg[i].tick = chan_tick(ci, st.channel_clock_pick[i], ticks); // [R14]
      cfg[i].center = st.alignment_select_reg[i]; // [R1] [R18]
      cfg[i].pol = st.polarity_reg[i]; // [R14] [R22]
      cfg[i].clr = clr[i];
      if (j && odd) begin
        cfg[i].per = {mem_words[hi], mem_words[ci]}; // [R13] [R23]
        cfg[i].dty = {mem_words[{1'b1, hi}], mem_words[{1'b1, ci}]}; // [R13] [R23]
      end else begin
        cfg[i].per = {8'h00, mem_words[ci]};
        cfg[i].dty = {8'h00, mem_words[{1'b1, ci}]};
      end
      next_st.ch[i] = step_chan(st.ch[i], cfg[i]); // [R2] [R6] [R10] [R4]
      next_st.pins[i] = st.ch[i].out; // [R8] [R14]
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '{channel_enable: `PWMC_RST_CTRL, polarity_reg: `PWMC_RST_CTRL,
              channel_clock_pick: `PWMC_RST_CTRL, alignment_select_reg: `PWMC_RST_CTRL,
              pair_join_control_reg: `PWMC_RST_JOIN, rdata: 32'h00000000,
              pins: 8'h00, ch: '0};
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata = st.rdata;
  assign wave_pin = st.pins;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_run(int k);
    cfg[k].en && cfg[k].tick && !cfg[k].clr && st.ch[k].per != 16'h0000;
  endsequence

  for (genvar k = 0; k < 8; k++) begin : g_chk
    chk_left_count_up: assert property (s_run(k) ##0 !cfg[k].center // [R2]
      && st.ch[k].cnt < st.ch[k].per - 16'h0001
      |=> st.ch[k].cnt == $past(st.ch[k].cnt) + 16'h0001)
      else $error("left counter did not step up");
    chk_left_wrap_load: assert property (s_run(k) ##0 !cfg[k].center // [R3]
      && st.ch[k].cnt >= st.ch[k].per - 16'h0001
      |=> st.ch[k].cnt == 16'h0000 && st.ch[k].per == $past(cfg[k].per)
      && st.ch[k].dty == $past(cfg[k].dty))
      else $error("left wrap did not clear and load");
    chk_center_up_zero: assert property (s_run(k) ##0 cfg[k].center // [R6]
      && st.ch[k].cnt == 16'h0000 |=> !st.ch[k].down && st.ch[k].cnt == 16'h0001)
      else $error("center counter not going up from zero");
    chk_center_turn_down: assert property (s_run(k) ##0 cfg[k].center // [R7]
      && !st.ch[k].down && st.ch[k].cnt == st.ch[k].per && st.ch[k].per > 16'h0001
      |=> st.ch[k].down && st.ch[k].cnt == $past(st.ch[k].cnt) - 16'h0001)
      else $error("center counter did not turn at period");
    chk_center_bottom: assert property (s_run(k) ##0 cfg[k].center // [R9]
      && st.ch[k].down && st.ch[k].cnt == 16'h0001
      |=> !st.ch[k].down && st.ch[k].cnt == 16'h0000 && st.ch[k].per == $past(cfg[k].per))
      else $error("center bottom did not turn up and load");
    chk_idle_period: assert property (cfg[k].en && !cfg[k].clr // [R20]
      && st.ch[k].per == 16'h0000
      |=> st.ch[k].cnt == 16'h0000 && st.ch[k].out == $past(cfg[k].pol))
      else $error("zero period not held");
    chk_zero_duty: assert property (cfg[k].en && st.ch[k].per != 16'h0000 // [R19]
      && st.ch[k].dty == 16'h0000 |=> st.ch[k].out == !$past(cfg[k].pol))
      else $error("zero duty level wrong");
    chk_full_duty: assert property (cfg[k].en && st.ch[k].per != 16'h0000 // [R21]
      && st.ch[k].dty != 16'h0000 && st.ch[k].dty >= st.ch[k].per
      |=> st.ch[k].out == $past(cfg[k].pol) ##1 wave_pin[k] == $past(cfg[k].pol, 2))
      else $error("full duty level wrong");
    chk_counter_clear: assert property (cfg[k].clr // [R16]
      |=> st.ch[k].cnt == 16'h0000 && !st.ch[k].down)
      else $error("counter write did not clear");
    chk_left_no_down: assert property (s_run(k) ##0 !cfg[k].center // [R2]
      && !st.ch[k].down |=> !st.ch[k].down)
      else $error("left counter turned down");
    chk_left_level: assert property (cfg[k].en && !st.ch[k].down // [R22]
      && st.ch[k].per != 16'h0000 && st.ch[k].dty != 16'h0000 && st.ch[k].dty < st.ch[k].per
      |=> st.ch[k].out == (($past(st.ch[k].cnt) < $past(st.ch[k].dty)) ? $past(cfg[k].pol)
      : !$past(cfg[k].pol)))
      else $error("rising count level wrong");
    chk_center_level: assert property (cfg[k].en && st.ch[k].down // [R8]
      && st.ch[k].per != 16'h0000 && st.ch[k].dty != 16'h0000 && st.ch[k].dty < st.ch[k].per
      |=> st.ch[k].out == (($past(st.ch[k].cnt) <= $past(st.ch[k].dty)) ? $past(cfg[k].pol)
      : !$past(cfg[k].pol)))
      else $error("falling count level wrong");
  end

  for (genvar p = 0; p < 4; p++) begin : g_pair
    chk_even_off: assert property (st.pair_join_control_reg[p] [*3] // [R15]
      |-> wave_pin[2 * p] == 1'b0)
      else $error("even half of joined pair drives output");
    chk_even_quiet: assert property (st.pair_join_control_reg[p] |-> !cfg[2 * p].en) // [R15]
      else $error("even half of joined pair enabled");
    chk_join_width: assert property (st.pair_join_control_reg[p] // [R13] [R23]
      |-> cfg[2 * p + 1].per == {mem_words[2 * p], mem_words[2 * p + 1]}
      && cfg[2 * p + 1].dty == {mem_words[2 * p + 8], mem_words[2 * p + 9]})
      else $error("joined compare values not sixteen bits");
  end

endmodule : pwmc_top
